// File: bsu_pkg.sv
// Package of operation codes, flag positions and timing constants for the branch and skip unit.
package bsu_pkg;

    // Operations the unit decides on.
    typedef enum logic [4:0] {
        OP_NONE, OP_CMP_IMM, OP_SKIP_REG_ZERO, OP_SKIP_REG_ONE, OP_SKIP_IO_ZERO, OP_SKIP_IO_ONE,
        OP_BR_FLAG_ONE, OP_BR_FLAG_ZERO, OP_BR_EQUAL, OP_BR_NOT_EQUAL, OP_BR_CARRY_ONE,
        OP_BR_CARRY_ZERO, OP_BR_SAME_OR_HIGHER, OP_BR_LOWER, OP_BR_MINUS, OP_BR_PLUS,
        OP_BR_SIGNED_GE, OP_BR_SIGNED_LT
    } bsu_op_t;

    // Flag positions inside the status flags register.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    // Cycle counts reported for each outcome.
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // Program counter steps in words.
    localparam logic [15:0] PC_STEP_ONE   = 16'h0001;
    localparam logic [15:0] PC_STEP_TWO   = 16'h0002;
    localparam logic [15:0] PC_STEP_THREE = 16'h0003;

    // Reset value of the program counter output.
    localparam logic [15:0] PC_RESET = 16'h0000;

endpackage

// File: bsu_compare.sv
// Compare of a working register with an immediate constant, flags only.
`timescale 1ns/1ps
module bsu_compare #(
    parameter int WIDTH = 8
) (
    // Operands.
    input  wire logic [WIDTH-1:0] reg_value,
    input  wire logic [WIDTH-1:0] imm_value,
    // Resulting flags.
    output logic                  flag_z,
    output logic                  flag_n,
    output logic                  flag_v,
    output logic                  flag_c,
    output logic                  flag_h,
    output logic                  flag_s
);
    // Top bit of the low half, where the half borrow is taken.
    localparam int HALF_MSB = WIDTH / 2 - 1;

    logic [WIDTH:0] diff;

    // Subtract without keeping the difference and derive the arithmetic flags.
    always_comb
    begin
        diff   = {1'b0, reg_value} - {1'b0, imm_value};
        flag_z = (diff[WIDTH-1:0] == '0);
        flag_n = diff[WIDTH-1];
        flag_v = (reg_value[WIDTH-1] & ~imm_value[WIDTH-1] & ~diff[WIDTH-1])
               | (~reg_value[WIDTH-1] & imm_value[WIDTH-1] & diff[WIDTH-1]);
        flag_c = diff[WIDTH];
        flag_h = (~reg_value[HALF_MSB] & imm_value[HALF_MSB]) | (imm_value[HALF_MSB] & diff[HALF_MSB])
               | (diff[HALF_MSB] & ~reg_value[HALF_MSB]);
        flag_s = flag_n ^ flag_v;
    end
endmodule // bsu_compare

// File: bsu_bit_select.sv
// Selection of one bit out of a byte by a bit index.
`timescale 1ns/1ps
module bsu_bit_select #(
    parameter int WIDTH = 8
) (
    // Source byte and bit index.
    input  wire logic [WIDTH-1:0]         value,
    input  wire logic [$clog2(WIDTH)-1:0] index,
    // Selected bit.
    output logic                          bit_out
);
    // Pick the addressed bit.
    assign bit_out = value[index];
endmodule // bsu_bit_select

// File: bsu_branch_skip_unit.sv
// Decision logic for compare-immediate, skip and relative branch operations.
// What this block does
// RULE_01: Compare immediate subtracts constant, keeps no result, updates Z N V C H, one cycle.
// RULE_02: Register bit zero skip jumps past next instruction, 1, 2 or 3 cycles.
// RULE_03: Register bit one skip jumps past next instruction, 1, 2 or 3 cycles.
// RULE_04: I/O bit zero skip jumps past next instruction, 1, 2 or 3 cycles.
// RULE_05: I/O bit one skip jumps past next instruction, 1, 2 or 3 cycles.
// RULE_06: Selected flag one branches to PC plus offset plus one, 1 or 2 cycles.
// RULE_07: Selected flag zero branches to PC plus offset plus one, 1 or 2 cycles.
// RULE_08: Carry zero branch jumps relative; taken costs 2 cycles, untaken 1.
// RULE_09: Same or higher branch jumps relative exactly when carry is zero.
// RULE_10: Signed greater or equal branch jumps when N xor V is zero.
// RULE_11: Signed less than branch jumps when N xor V is one, flags untouched.
// RULE_12: Equal, not equal, carry, lower, minus, plus test Z, C, N accordingly.
`timescale 1ns/1ps
module bsu_branch_skip_unit #(
    parameter int DATA_WIDTH = 8,
    parameter int PC_WIDTH   = 16,
    parameter int OFS_WIDTH  = 7
) (
    // Clock and reset.
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    // Request.
    input  wire logic                          op_valid,
    input  wire bsu_pkg::bsu_op_t              op_code,
    input  wire logic [PC_WIDTH-1:0]           pc_current,
    input  wire logic [DATA_WIDTH-1:0]         reg_value,
    input  wire logic [DATA_WIDTH-1:0]         imm_value,
    input  wire logic [DATA_WIDTH-1:0]         io_value,
    input  wire logic [$clog2(DATA_WIDTH)-1:0] bit_index,
    input  wire logic [OFS_WIDTH-1:0]          branch_offset,
    input  wire logic                          next_is_two_words,
    input  wire logic [DATA_WIDTH-1:0]         status_flags_register,
    // Result.
    output logic                               result_valid,
    output logic [PC_WIDTH-1:0]                pc_next,
    output logic [1:0]                         cycle_count,
    output logic                               pc_redirect,
    output logic                               flags_write,
    output logic [DATA_WIDTH-1:0]              flags_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Operand helpers.
    // Everything in this section is combinational and settles within the request cycle.

    // Compare flags, selected bits and the extended offset.
    logic                   cmp_z;
    logic                   cmp_n;
    logic                   cmp_v;
    logic                   cmp_c;
    logic                   cmp_h;
    logic                   cmp_s;
    logic                   reg_bit;
    logic                   io_bit;
    logic                   flag_bit;
    logic [PC_WIDTH-1:0]    offset_ext;

    // Flags of the compare; the difference itself is never stored.
    // The compare runs on every request, and only the registered stage decides whether its flags count.
    bsu_compare #(.WIDTH(DATA_WIDTH)) u_compare (
        .reg_value (reg_value),
        .imm_value (imm_value),
        .flag_z    (cmp_z),
        .flag_n    (cmp_n),
        .flag_v    (cmp_v),
        .flag_c    (cmp_c),
        .flag_h    (cmp_h),
        .flag_s    (cmp_s)
    );

    // One bit picker per source: working register, I/O register and status flags.
    // All three share the bit index, because only one operation is decided per request
    // and each operation reads one source only.
    bsu_bit_select #(.WIDTH(DATA_WIDTH)) u_reg_bit (
        .value   (reg_value),
        .index   (bit_index),
        .bit_out (reg_bit)
    );

    bsu_bit_select #(.WIDTH(DATA_WIDTH)) u_io_bit (
        .value   (io_value),
        .index   (bit_index),
        .bit_out (io_bit)
    );

    bsu_bit_select #(.WIDTH(DATA_WIDTH)) u_flag_bit (
        .value   (status_flags_register),
        .index   (bit_index),
        .bit_out (flag_bit)
    );

    // Sign extension of the relative offset to the program counter width.
    // The offset is a two's complement word count, so a backward branch adds a large value.
    // The sum wraps at the program counter width, which lets a branch near the top of memory reach
    // the bottom and the other way round, as a plain adder of that width would.
    assign offset_ext = {{(PC_WIDTH-OFS_WIDTH){branch_offset[OFS_WIDTH-1]}}, branch_offset};

    ////////////////////////////////////////////////////////////////////////////////
    // Decision.

    // Decoded class, condition and the values that the registered stage loads.
    logic                   is_skip;
    logic                   is_branch;
    logic                   cond;
    logic [PC_WIDTH-1:0]    next_pc;
    logic [1:0]             next_cycles;
    logic [DATA_WIDTH-1:0]  next_flags;

    // Work out the condition of the requested operation.
    // Every path starts from cleared defaults, so an unused or illegal code can neither skip nor branch.
    // Codes that are not skips or branches leave cond low, which keeps pc_redirect low for them.
    // The flag branches pick their flag by the bit index; the named branches use fixed flag positions.
    // Carry one and lower share one arm; carry zero and same or higher have separate arms with identical conditions.
    always_comb
    begin
        is_skip   = 1'b0;
        is_branch = 1'b0;
        cond      = 1'b0;
        unique case (op_code)
            bsu_pkg::OP_NONE, bsu_pkg::OP_CMP_IMM:
            begin
                cond = 1'b0;
            end
            bsu_pkg::OP_SKIP_REG_ZERO:
            begin
                is_skip = 1'b1;
                cond    = ~reg_bit; // RULE_02
            end
            bsu_pkg::OP_SKIP_REG_ONE:
            begin
                is_skip = 1'b1;
                cond    = reg_bit; // RULE_03
            end
            bsu_pkg::OP_SKIP_IO_ZERO:
            begin
                is_skip = 1'b1;
                cond    = ~io_bit; // RULE_04
            end
            bsu_pkg::OP_SKIP_IO_ONE:
            begin
                is_skip = 1'b1;
                cond    = io_bit; // RULE_05
            end
            bsu_pkg::OP_BR_FLAG_ONE:
            begin
                is_branch = 1'b1;
                cond      = flag_bit; // RULE_06
            end
            bsu_pkg::OP_BR_FLAG_ZERO:
            begin
                is_branch = 1'b1;
                cond      = ~flag_bit; // RULE_07
            end
            bsu_pkg::OP_BR_EQUAL:
            begin
                is_branch = 1'b1;
                cond      = status_flags_register[bsu_pkg::FLAG_Z]; // RULE_12
            end
            bsu_pkg::OP_BR_NOT_EQUAL:
            begin
                is_branch = 1'b1;
                cond      = ~status_flags_register[bsu_pkg::FLAG_Z]; // RULE_12
            end
            bsu_pkg::OP_BR_CARRY_ONE, bsu_pkg::OP_BR_LOWER:
            begin
                is_branch = 1'b1;
                cond      = status_flags_register[bsu_pkg::FLAG_C]; // RULE_12
            end
            bsu_pkg::OP_BR_CARRY_ZERO:
            begin
                is_branch = 1'b1;
                cond      = ~status_flags_register[bsu_pkg::FLAG_C]; // RULE_08
            end
            bsu_pkg::OP_BR_SAME_OR_HIGHER:
            begin
                is_branch = 1'b1;
                cond      = ~status_flags_register[bsu_pkg::FLAG_C]; // RULE_09
            end
            bsu_pkg::OP_BR_MINUS:
            begin
                is_branch = 1'b1;
                cond      = status_flags_register[bsu_pkg::FLAG_N]; // RULE_12
            end
            bsu_pkg::OP_BR_PLUS:
            begin
                is_branch = 1'b1;
                cond      = ~status_flags_register[bsu_pkg::FLAG_N]; // RULE_12
            end
            bsu_pkg::OP_BR_SIGNED_GE:
            begin
                is_branch = 1'b1;
                cond      = ~(status_flags_register[bsu_pkg::FLAG_N]
                            ^ status_flags_register[bsu_pkg::FLAG_V]); // RULE_10
            end
            bsu_pkg::OP_BR_SIGNED_LT:
            begin
                is_branch = 1'b1;
                cond      = status_flags_register[bsu_pkg::FLAG_N]
                          ^ status_flags_register[bsu_pkg::FLAG_V]; // RULE_11
            end
            default:
            begin
                cond = 1'b0;
            end
        endcase
    end

    // Next program counter and cycle cost for the decided outcome.
    // The fall-through value is the default, so only a met condition moves the target.
    // A skip passes over one or two words, depending on the length of the instruction after it,
    // and costs one extra cycle per word skipped.
    // A taken branch always costs two cycles, whatever its distance.
    always_comb
    begin
        next_pc     = pc_current + bsu_pkg::PC_STEP_ONE[PC_WIDTH-1:0];
        next_cycles = bsu_pkg::CYC_ONE; // RULE_01
        if (is_skip && cond)
        begin
            if (next_is_two_words)
            begin
                next_pc     = pc_current + bsu_pkg::PC_STEP_THREE[PC_WIDTH-1:0]; // RULE_02
                next_cycles = bsu_pkg::CYC_THREE; // RULE_03
            end
            else
            begin
                next_pc     = pc_current + bsu_pkg::PC_STEP_TWO[PC_WIDTH-1:0]; // RULE_04
                next_cycles = bsu_pkg::CYC_TWO; // RULE_05
            end
        end
        else if (is_branch && cond)
        begin
            next_pc     = pc_current + offset_ext + bsu_pkg::PC_STEP_ONE[PC_WIDTH-1:0]; // RULE_06
            next_cycles = bsu_pkg::CYC_TWO; // RULE_08
        end
    end

    // Compare updates Z, N, V, C, H and the sign flag; other bits and operations keep the flags.
    // All bits are computed for every request; the registered stage only keeps them for a compare,
    // so branches and skips hand the incoming flags back untouched.
    // Bits outside the arithmetic flags always pass through unchanged.
    always_comb
    begin
        next_flags                   = status_flags_register; // RULE_11
        next_flags[bsu_pkg::FLAG_Z]  = cmp_z; // RULE_01
        next_flags[bsu_pkg::FLAG_N]  = cmp_n;
        next_flags[bsu_pkg::FLAG_V]  = cmp_v;
        next_flags[bsu_pkg::FLAG_C]  = cmp_c;
        next_flags[bsu_pkg::FLAG_H]  = cmp_h;
        next_flags[bsu_pkg::FLAG_S]  = cmp_s;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    // Every output comes straight from a flip-flop, so downstream timing sees no decode logic.

    // Result strobe and program counter outcome.
    // The strobe is a single-cycle pulse per accepted request.
    // Target, cost and redirect are loaded only on a request and hold until the next one,
    // so a slow consumer may read them at any time after the strobe.
    // A request with no operation still moves the target to the next word but raises no strobe.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            result_valid <= 1'b0;
            pc_next      <= bsu_pkg::PC_RESET[PC_WIDTH-1:0];
            cycle_count  <= bsu_pkg::CYC_ONE;
            pc_redirect  <= 1'b0;
        end
        else
        begin
            result_valid <= op_valid && (op_code != bsu_pkg::OP_NONE);
            if (op_valid)
            begin
                pc_next     <= next_pc; // RULE_07
                cycle_count <= next_cycles;
                pc_redirect <= cond && (is_skip || is_branch);
            end
        end
    end

    // Flag write-back, issued only by the compare operation.
    // The flag output follows the input flags for every other request,
    // so a consumer that ignores the write strobe still sees consistent flags.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            flags_write <= 1'b0;
            flags_out   <= '0;
        end
        else
        begin
            flags_write <= op_valid && (op_code == bsu_pkg::OP_CMP_IMM); // RULE_01
            if (op_valid)
            begin
                flags_out <= (op_code == bsu_pkg::OP_CMP_IMM) ? next_flags : status_flags_register;
            end
        end
    end

endmodule // bsu_branch_skip_unit

// File: bsu_branch_skip_unit_sva.sv
// Checker of the branch and skip unit's result timing and decisions.
`timescale 1ns/1ps
module bsu_branch_skip_unit_sva #(
    parameter int DATA_WIDTH = 8,
    parameter int PC_WIDTH   = 16,
    parameter int OFS_WIDTH  = 7
) (
    // Clock, reset and request.
    input wire logic                          mclk,
    input wire logic                          reset_n,
    input wire logic                          op_valid,
    input wire bsu_pkg::bsu_op_t              op_code,
    input wire logic [PC_WIDTH-1:0]           pc_current,
    input wire logic [DATA_WIDTH-1:0]         reg_value,
    input wire logic [DATA_WIDTH-1:0]         imm_value,
    input wire logic [DATA_WIDTH-1:0]         io_value,
    input wire logic [$clog2(DATA_WIDTH)-1:0] bit_index,
    input wire logic [OFS_WIDTH-1:0]          branch_offset,
    input wire logic                          next_is_two_words,
    input wire logic [DATA_WIDTH-1:0]         status_flags_register,
    // Result.
    input wire logic                          result_valid,
    input wire logic [PC_WIDTH-1:0]           pc_next,
    input wire logic [1:0]                    cycle_count,
    input wire logic                          pc_redirect,
    input wire logic                          flags_write,
    input wire logic [DATA_WIDTH-1:0]         flags_out
);
    // All checks run on the core clock and rest while reset is low.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    property p_answer; op_valid && op_code != bsu_pkg::OP_NONE |=> result_valid; endproperty
    a_answer: assert property (p_answer) else $error("result missing after request");
    property p_cmp; op_valid && op_code == bsu_pkg::OP_CMP_IMM |=> flags_write && cycle_count == bsu_pkg::CYC_ONE
        && flags_out[bsu_pkg::FLAG_Z] == ($past(reg_value) == $past(imm_value)); endproperty
    a_cmp: assert property (p_cmp) else $error("compare flags or cost wrong");
    property p_flag_keep; op_valid && op_code >= bsu_pkg::OP_SKIP_REG_ZERO |=> !flags_write
        && flags_out == $past(status_flags_register); endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flags altered by branch or skip");
    property p_skip_reg; op_valid && op_code == bsu_pkg::OP_SKIP_REG_ZERO && !reg_value[bit_index] |=> pc_redirect
        && pc_next == $past(pc_current) + ($past(next_is_two_words) ? bsu_pkg::PC_STEP_THREE : bsu_pkg::PC_STEP_TWO);
    endproperty
    a_skip_reg: assert property (p_skip_reg) else $error("register bit skip target wrong");
    property p_skip_io; op_valid && op_code == bsu_pkg::OP_SKIP_IO_ONE && io_value[bit_index] |=> pc_redirect
        && cycle_count == ($past(next_is_two_words) ? bsu_pkg::CYC_THREE : bsu_pkg::CYC_TWO); endproperty
    a_skip_io: assert property (p_skip_io) else $error("io bit skip cost wrong");
    property p_taken_cost; result_valid && pc_redirect && $past(op_code) >= bsu_pkg::OP_BR_FLAG_ONE
        |-> cycle_count == bsu_pkg::CYC_TWO; endproperty
    a_taken_cost: assert property (p_taken_cost) else $error("taken branch cost wrong");
    property p_untaken; result_valid && !pc_redirect |-> cycle_count == bsu_pkg::CYC_ONE
        && pc_next == $past(pc_current) + bsu_pkg::PC_STEP_ONE; endproperty
    a_untaken: assert property (p_untaken) else $error("fall through wrong");
    property p_signed_lt; op_valid && op_code == bsu_pkg::OP_BR_SIGNED_LT |=> pc_redirect
        == $past(status_flags_register[bsu_pkg::FLAG_N] ^ status_flags_register[bsu_pkg::FLAG_V]); endproperty
    a_signed_lt: assert property (p_signed_lt) else $error("signed less than decision wrong");
    property p_target; op_valid && op_code == bsu_pkg::OP_BR_EQUAL && status_flags_register[bsu_pkg::FLAG_Z]
        |=> pc_next == $past(pc_current) + PC_WIDTH'($signed($past(branch_offset))) + bsu_pkg::PC_STEP_ONE;
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");
endmodule // bsu_branch_skip_unit_sva

// File: bsu_branch_skip_unit_tb.sv
// Self-checking testbench of the branch and skip unit.
`timescale 1ns/1ps
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module bsu_branch_skip_unit_tb;
    // Stimulus and observed signals.
    logic             mclk = 1'b0;
    logic             reset_n = 1'b0;
    logic             op_valid = 1'b0;
    bsu_pkg::bsu_op_t op_code = bsu_pkg::OP_NONE;
    logic [15:0]      pc_current = 16'h0000;
    logic [7:0]       reg_value = 8'h00;
    logic [7:0]       imm_value = 8'h00;
    logic [7:0]       io_value = 8'h00;
    logic [2:0]       bit_index = 3'h0;
    logic [6:0]       branch_offset = 7'h00;
    logic             next_is_two_words = 1'b0;
    logic [7:0]       status_flags_register = 8'h00;
    logic             result_valid, pc_redirect, flags_write;
    logic [15:0]      pc_next;
    logic [1:0]       cycle_count;
    logic [7:0]       flags_out;
    int               err_total = 0;
    int               tests_run = 0;
    // Core clock at 50 MHz.
    always #10 mclk = ~mclk;
    bsu_branch_skip_unit u_bsu_branch_skip_unit (.mclk, .reset_n, .op_valid, .op_code, .pc_current, .reg_value,
        .imm_value, .io_value, .bit_index, .branch_offset, .next_is_two_words, .status_flags_register,
        .result_valid, .pc_next, .cycle_count, .pc_redirect, .flags_write, .flags_out);
    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Pulses the request one edge after the operands were set; returns once the result has landed.
    task automatic fire();
        @(posedge mclk);
        #1 op_valid = 1'b1;
        @(posedge mclk);
        #1 op_valid = 1'b0;
    endtask
    // Compares one answer with the expected target, cost and redirect.
    task automatic expect_res(logic [15:0] pc, logic [1:0] cyc, logic red);
        `CHECK(result_valid, 1'b1)
        `CHECK(pc_next, pc)
        `CHECK(cycle_count, cyc)
        `CHECK(pc_redirect, red)
    endtask
    // Expected decision of the named flag branches on C, Z, N, V.
    function automatic logic cond(bsu_pkg::bsu_op_t op, logic [3:0] f);
        case (op)
            bsu_pkg::OP_BR_EQUAL:                                    return f[1];
            bsu_pkg::OP_BR_NOT_EQUAL:                                return !f[1];
            bsu_pkg::OP_BR_CARRY_ONE, bsu_pkg::OP_BR_LOWER:           return f[0];
            bsu_pkg::OP_BR_CARRY_ZERO, bsu_pkg::OP_BR_SAME_OR_HIGHER: return !f[0];
            bsu_pkg::OP_BR_MINUS:                                    return f[2];
            bsu_pkg::OP_BR_PLUS:                                     return !f[2];
            bsu_pkg::OP_BR_SIGNED_GE:                                return !(f[2] ^ f[3]);
            default:                                                 return f[2] ^ f[3];
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Outputs after reset, then an idle code that must raise no result.
    task automatic sc_reset_idle();
        `CHECK({result_valid, pc_next, cycle_count, pc_redirect, flags_write, flags_out}, 29'h00000400)
        pc_current = 16'h0077;
        fire();
        `CHECK(result_valid, 1'b0)
        `CHECK(pc_next, 16'h0078)
    endtask
    // Compare with zero, borrow, signed overflow and half borrow results.
    task automatic sc_compare();
        logic [7:0] ra [4] = '{8'h10, 8'h00, 8'h80, 8'h3F};
        logic [7:0] ia [4] = '{8'h10, 8'h01, 8'h01, 8'h48};
        logic [7:0] d;
        logic       v;
        for (int i = 0; i < 4; i++)
        begin
            op_code = bsu_pkg::OP_CMP_IMM;
            {reg_value, imm_value} = {ra[i], ia[i]};
            {status_flags_register, pc_current} = {8'hC0, 16'h0040};
            d = ra[i] - ia[i];
            v = (ra[i][7] & ~ia[i][7] & ~d[7]) | (~ra[i][7] & ia[i][7] & d[7]);
            fire();
            expect_res(16'h0041, 2'h1, 1'b0);
            `CHECK(flags_write, 1'b1)
            `CHECK(flags_out, {2'b11, ia[i][3:0] > ra[i][3:0], d[7] ^ v, v, d[7], ~|d, ia[i] > ra[i]})
        end
    endtask
    // Every skip code with the bit at both levels and both lengths of the next instruction.
    task automatic sc_skip();
        logic tk;
        logic [15:0] ep;
        for (int o = 0; o < 4; o++)
            for (int b = 0; b < 2; b++)
                for (int w = 0; w < 2; w++)
                begin
                    op_code = bsu_pkg::bsu_op_t'(int'(bsu_pkg::OP_SKIP_REG_ZERO) + o);
                    reg_value = ((o < 2) == (b == 1)) ? 8'h20 : 8'hDF;
                    {io_value, bit_index, next_is_two_words, pc_current} = {~reg_value, 3'h5, w[0], 16'h1234};
                    tk = (o % 2 == 0) == (b == 0);
                    fire();
                    ep = tk ? 16'h1236 + 16'(w) : 16'h1235;
                    expect_res(ep, tk ? 2'h2 + 2'(w) : 2'h1, tk);
                end
    endtask
    // Selected flag branches on every flag position with a backward offset.
    task automatic sc_flag_branch();
        logic tk;
        for (int i = 0; i < 8; i++)
            for (int o = 0; o < 2; o++)
            begin
                op_code = bsu_pkg::bsu_op_t'(int'(bsu_pkg::OP_BR_FLAG_ONE) + o);
                {status_flags_register, bit_index, branch_offset, pc_current} = {8'hA5, 3'(i), 7'h7D, 16'h0100};
                tk = status_flags_register[i] ^ o[0];
                fire();
                expect_res(tk ? 16'h00FE : 16'h0101, tk ? 2'h2 : 2'h1, tk);
            end
    endtask
    // Reset in mid-run after activity must bring every output back to its reset value.
    task automatic sc_mid_reset();
        pc_current = 16'h0200;
        fire();
        `CHECK(pc_next, 16'h0201)
        @(posedge mclk);
        #1 reset_n = 1'b0;
        @(posedge mclk);
        #1 reset_n = 1'b1;
        `CHECK({result_valid, pc_next, cycle_count, pc_redirect, flags_write, flags_out}, 29'h00000400)
    endtask
    // Named branches over all C, Z, N, V combinations, largest forward offset with wrap.
    task automatic sc_named();
        logic tk;
        for (int i = int'(bsu_pkg::OP_BR_EQUAL); i <= int'(bsu_pkg::OP_BR_SIGNED_LT); i++)
            for (int f = 0; f < 16; f++)
            begin
                op_code = bsu_pkg::bsu_op_t'(i);
                status_flags_register = {3'h0, ~(f[2] ^ f[3]), 4'(f)};
                {branch_offset, pc_current} = {7'h3F, 16'hFFF0};
                tk = cond(op_code, 4'(f));
                fire();
                expect_res(tk ? 16'h0030 : 16'hFFF1, tk ? 2'h2 : 2'h1, tk);
                `CHECK({flags_write, flags_out}, {1'b0, status_flags_register})
            end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for five cycles, then every scenario.
    initial
    begin
        repeat (5) @(posedge mclk);
        #1 reset_n = 1'b1;
        sc_reset_idle();
        sc_compare();
        sc_skip();
        sc_flag_branch();
        sc_mid_reset();
        sc_named();
        tally_and_finish();
    end
    // Cuts a hang short and counts it as a mismatch.
    initial
    begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule // bsu_branch_skip_unit_tb
bind bsu_branch_skip_unit bsu_branch_skip_unit_sva
    #(.DATA_WIDTH(DATA_WIDTH), .PC_WIDTH(PC_WIDTH), .OFS_WIDTH(OFS_WIDTH))
    u_bsu_branch_skip_unit_sva (.mclk, .reset_n, .op_valid, .op_code, .pc_current, .reg_value, .imm_value,
    .io_value, .bit_index, .branch_offset, .next_is_two_words, .status_flags_register, .result_valid, .pc_next,
    .cycle_count, .pc_redirect, .flags_write, .flags_out);
